// ==== shared/lsaux_pkg.sv ====
// shared constants and carrier types for the line-side auxiliary block
package lsaux_pkg;
   // register offsets
   localparam logic [7:0] LINE_CFG_BASE = 8'h00;
   localparam logic [7:0] MON_CTRL_ADDR = 8'h13;
   localparam logic [7:0] REF_CTRL_ADDR = 8'h19;
   localparam logic [7:0] STATUS_ADDR = 8'h20;
   localparam logic [7:0] SER_SEL_ADDR = 8'h21;
   localparam logic [7:0] SER_DATA_ADDR = 8'h22;
   // line config fields (one register per channel)
   localparam int LCFG_POL_BIT = 0;
   localparam int LCFG_EN_BIT = 1;
   // monitor control fields
   localparam int MON_DIR_BIT = 0;
   localparam int MON_FRM_BIT = 2;
   localparam int MON_OE_BIT = 4;
   localparam int MON_CH_LSB = 6;
   // clock reference control fields
   localparam int REF_A_SRC_LSB = 0;
   localparam int REF_A_EN_BIT = 3;
   localparam int REF_RATE_BIT = 4;
   localparam int REF_B_EN_BIT = 5;
   localparam int REF_B_SRC_LSB = 6;
   // status fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_MODE_BIT = 1;
   localparam int STAT_LOS_LSB = 4;
   // reset values
   localparam logic [7:0] LINE_CFG_RST = 8'h00;
   localparam logic [7:0] MON_CTRL_RST = 8'h00;
   localparam logic [7:0] REF_CTRL_RST = 8'h00;
   localparam logic [1:0] SER_SEL_RST = 2'h0;
   // serial transfer length
   localparam logic [3:0] SER_BITS = 4'h8;
   localparam int CHANNELS = 4;

   typedef enum logic [1:0] {
      LSAUX_IDLE = 2'b00,
      LSAUX_SHIFT = 2'b01,
      LSAUX_END = 2'b11
   } lsaux_ser_t;

   // signals from one framer channel, all from foreign clock domains
   typedef struct packed {
      logic lineClk;
      logic frameClk;
      logic rxNrzClk;
      logic rxNrzData;
      logic rxFrameBit;
      logic txNrzClk;
      logic txNrzData;
      logic txFrameBit;
   } lsaux_framer_t;

   // tri-state pin drive: oeN low while driving
   typedef struct packed {
      logic out;
      logic oeN;
   } lsaux_pin_t;
endpackage

// ==== rtl/lsaux_line_side.sv ====
// line-side auxiliary logic: alarms, transceiver serial port, monitor, clock refs
`timescale 1ns/10ps

module lsaux_line_side (
   // clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   // framer side
   input wire lsaux_pkg::lsaux_framer_t [3:0] framerIn,
   input wire logic [3:0] intLos,
   output logic [3:0] losAlarm,
   // pins
   input wire logic [3:0] extAlarmInN,
   input wire logic portModePin,
   input wire logic serialClockSourceIn,
   output logic [3:0] xcvrSelectN,
   output lsaux_pkg::lsaux_pin_t sclkPin,
   output lsaux_pkg::lsaux_pin_t sdoPin,
   input wire logic sdiPinIn,
   output lsaux_pkg::lsaux_pin_t sdiPin,
   output lsaux_pkg::lsaux_pin_t refClockOutA,
   output lsaux_pkg::lsaux_pin_t refClockOutB
);

   // select one of four lanes; value 0 is channel one
   function automatic logic pickLane(input logic [1:0] sel, input logic [3:0] lanes);
      pickLane = lanes[sel];
   endfunction

   // synchronisers for every foreign input
   localparam int SW = 8 * lsaux_pkg::CHANNELS + 4 + 3;
   logic [SW-1:0] syncA_r;
   logic [SW-1:0] syncB_r;
   wire [SW-1:0] rawIn = {framerIn, extAlarmInN, portModePin, serialClockSourceIn, sdiPinIn};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         syncA_r <= '0;
         syncB_r <= '0;
      end else if (ce) begin
         syncA_r <= rawIn;
         syncB_r <= syncA_r;
      end
   end

   lsaux_pkg::lsaux_framer_t [3:0] fr;
   wire [3:0] extAlarmS = syncB_r[6:3];
   wire modeMon = syncB_r[2];
   wire loS = syncB_r[1];
   wire sdiS = syncB_r[0];
   assign fr = syncB_r[SW-1:7];

   // registers
   logic [7:0] lineCfg_r [4];
   logic [7:0] monCtrl_r;
   logic [7:0] refCtrl_r;
   logic [1:0] serSel_r;
   logic [7:0] txSh_r;
   logic [7:0] rxSh_r;
   logic [7:0] rdData_r;

   wire wrMon = regWr && regAddr == lsaux_pkg::MON_CTRL_ADDR;
   wire wrRef = regWr && regAddr == lsaux_pkg::REF_CTRL_ADDR;
   wire wrSel = regWr && regAddr == lsaux_pkg::SER_SEL_ADDR;
   wire wrData = regWr && regAddr == lsaux_pkg::SER_DATA_ADDR;
   wire cfgHit = regAddr[7:2] == lsaux_pkg::LINE_CFG_BASE[7:2];

   genvar g;
   generate
      for (g = 0; g < lsaux_pkg::CHANNELS; g++) begin : gCh
         wire wrCfg = regWr && cfgHit && regAddr[1:0] == 2'(g);
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               lineCfg_r[g] <= lsaux_pkg::LINE_CFG_RST;
            end else if (ce && wrCfg) begin
               lineCfg_r[g] <= regWrData;
            end
         end
         // alarm path is independent of line coding mode
         wire extActive = extAlarmS[g] ^ lineCfg_r[g][lsaux_pkg::LCFG_POL_BIT];
         assign losAlarm[g] = intLos[g] |
            (lineCfg_r[g][lsaux_pkg::LCFG_EN_BIT] & extActive);
      end
   endgenerate

   // serial clock: LO divided by two
   logic loD_r;
   logic sclk_r;
   wire loRise = loS & ~loD_r;
   wire sclkRise = loRise & ~sclk_r;
   wire sclkFall = loRise & sclk_r;

   // serial engine state
   lsaux_pkg::lsaux_ser_t st_r;
   lsaux_pkg::lsaux_ser_t st_nxt;
   logic [3:0] cnt_r;
   wire busy = st_r != lsaux_pkg::LSAUX_IDLE;
   wire start = wrData && !busy && !modeMon;
   wire lastFall = sclkFall && cnt_r == lsaux_pkg::SER_BITS;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         lsaux_pkg::LSAUX_IDLE: begin
            if (start) begin
               st_nxt = lsaux_pkg::LSAUX_SHIFT;
            end
         end
         lsaux_pkg::LSAUX_SHIFT: begin
            if (lastFall) begin
               st_nxt = lsaux_pkg::LSAUX_END;
            end
         end
         lsaux_pkg::LSAUX_END: st_nxt = lsaux_pkg::LSAUX_IDLE;
         default: st_nxt = lsaux_pkg::LSAUX_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         loD_r <= 1'b0;
         sclk_r <= 1'b0;
         st_r <= lsaux_pkg::LSAUX_IDLE;
      end else if (ce) begin
         loD_r <= loS;
         if (loRise) begin
            sclk_r <= ~sclk_r;
         end
         st_r <= st_nxt;
      end
   end

   // shift registers; a fall before the first rise does not shift
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 4'h0;
         txSh_r <= 8'h00;
         rxSh_r <= 8'h00;
      end else if (ce) begin
         if (start) begin
            cnt_r <= 4'h0;
            txSh_r <= regWrData;
         end else if (st_r == lsaux_pkg::LSAUX_SHIFT) begin
            if (sclkRise) begin
               rxSh_r <= {rxSh_r[6:0], sdiS};
               cnt_r <= cnt_r + 4'h1;
            end else if (sclkFall && cnt_r != 4'h0) begin
               txSh_r <= {txSh_r[6:0], 1'b0};
            end
         end
      end
   end

   // control registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         monCtrl_r <= lsaux_pkg::MON_CTRL_RST;
         refCtrl_r <= lsaux_pkg::REF_CTRL_RST;
         serSel_r <= lsaux_pkg::SER_SEL_RST;
      end else if (ce) begin
         if (wrMon) begin
            monCtrl_r <= regWrData;
         end
         if (wrRef) begin
            refCtrl_r <= regWrData;
         end
         if (wrSel && !busy) begin
            serSel_r <= regWrData[1:0];
         end
      end
   end

   // read port, data one cycle after the strobe
   wire [7:0] statusVal = {losAlarm, 2'b00, modeMon, busy};
   wire [1:0] cfgIdx = regAddr[1:0];
   wire [7:0] rdMux =
      cfgHit ? lineCfg_r[cfgIdx] :
      regAddr == lsaux_pkg::MON_CTRL_ADDR ? monCtrl_r :
      regAddr == lsaux_pkg::REF_CTRL_ADDR ? refCtrl_r :
      regAddr == lsaux_pkg::STATUS_ADDR ? statusVal :
      regAddr == lsaux_pkg::SER_SEL_ADDR ? {6'h00, serSel_r} :
      regAddr == lsaux_pkg::SER_DATA_ADDR ? rxSh_r : 8'h00;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdData_r <= 8'h00;
      end else if (ce) begin
         rdData_r <= regRd ? rdMux : 8'h00;
      end
   end
   assign regRdData = rdData_r;

   // monitor source selection
   wire [1:0] monCh = monCtrl_r[lsaux_pkg::MON_CH_LSB +: 2];
   wire monTx = monCtrl_r[lsaux_pkg::MON_DIR_BIT];
   wire [3:0] rxClkV = {fr[3].rxNrzClk, fr[2].rxNrzClk, fr[1].rxNrzClk, fr[0].rxNrzClk};
   wire [3:0] txClkV = {fr[3].txNrzClk, fr[2].txNrzClk, fr[1].txNrzClk, fr[0].txNrzClk};
   wire [3:0] rxDatV = {fr[3].rxNrzData, fr[2].rxNrzData, fr[1].rxNrzData, fr[0].rxNrzData};
   wire [3:0] txDatV = {fr[3].txNrzData, fr[2].txNrzData, fr[1].txNrzData, fr[0].txNrzData};
   wire [3:0] rxFrmV = {fr[3].rxFrameBit, fr[2].rxFrameBit, fr[1].rxFrameBit, fr[0].rxFrameBit};
   wire [3:0] txFrmV = {fr[3].txFrameBit, fr[2].txFrameBit, fr[1].txFrameBit, fr[0].txFrameBit};
   wire monClkSel = monTx ? pickLane(monCh, txClkV) : pickLane(monCh, rxClkV);
   wire monDatSel = monTx ? pickLane(monCh, txDatV) : pickLane(monCh, rxDatV);
   wire monFrmSel = monTx ? pickLane(monCh, txFrmV) : pickLane(monCh, rxFrmV);

   logic monitor_clk_r;
   logic monDat_r;
   logic monitor_frame_pulse_r;
   wire monClkRise = monClkSel & ~monitor_clk_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         monitor_clk_r <= 1'b0;
         monDat_r <= 1'b0;
         monitor_frame_pulse_r <= 1'b0;
      end else if (ce) begin
         monitor_clk_r <= monClkSel;
         monDat_r <= monDatSel;
         if (monClkRise) begin
            monitor_frame_pulse_r <= monFrmSel;
         end
      end
   end

   // clock references
   wire rateLine = refCtrl_r[lsaux_pkg::REF_RATE_BIT];
   wire [1:0] srcA = refCtrl_r[lsaux_pkg::REF_A_SRC_LSB +: 2];
   wire [1:0] srcB = refCtrl_r[lsaux_pkg::REF_B_SRC_LSB +: 2];
   wire [3:0] lineClkV = {fr[3].lineClk, fr[2].lineClk, fr[1].lineClk, fr[0].lineClk};
   wire [3:0] frameClkV = {fr[3].frameClk, fr[2].frameClk, fr[1].frameClk, fr[0].frameClk};
   wire [3:0] rateClkV = rateLine ? lineClkV : frameClkV;
   wire refAVal = pickLane(srcA, rateClkV) & ~pickLane(srcA, losAlarm);
   wire refBVal = pickLane(srcB, rateClkV) & ~pickLane(srcB, losAlarm);

   logic refA_r;
   logic refB_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         refA_r <= 1'b0;
         refB_r <= 1'b0;
      end else if (ce) begin
         refA_r <= refAVal;
         refB_r <= refBVal;
      end
   end
   assign refClockOutA.out = refA_r;
   assign refClockOutA.oeN = ~refCtrl_r[lsaux_pkg::REF_A_EN_BIT];
   assign refClockOutB.out = refB_r;
   assign refClockOutB.oeN = ~refCtrl_r[lsaux_pkg::REF_B_EN_BIT];

   // shared pins; transceiver mode always drives clock and data out
   wire monOe = monCtrl_r[lsaux_pkg::MON_OE_BIT];
   assign sclkPin.out = modeMon ? monitor_clk_r : sclk_r;
   assign sclkPin.oeN = modeMon & ~monOe;
   assign sdoPin.out = modeMon ? monDat_r : txSh_r[7];
   assign sdoPin.oeN = modeMon & ~monOe;
   assign sdiPin.out = monitor_frame_pulse_r;
   assign sdiPin.oeN = ~(modeMon & monCtrl_r[lsaux_pkg::MON_FRM_BIT]);

   // selects go high in monitor mode once a running transfer ends, since no new transfer can start there
   generate
      for (g = 0; g < lsaux_pkg::CHANNELS; g++) begin : gSel
         assign xcvrSelectN[g] = ~(busy && serSel_r == 2'(g));
      end
   endgenerate

endmodule

// ==== tb/lsaux_line_side_props.sv ====
// port-level checker for the line-side auxiliary block
`timescale 1ns/10ps
module lsaux_line_side_props (
   // clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdData,
   // alarms and pins
   input wire logic [3:0] intLos,
   input wire logic [3:0] losAlarm,
   input wire logic [3:0] extAlarmInN,
   input wire logic portModePin,
   input wire logic [3:0] xcvrSelectN,
   input wire lsaux_pkg::lsaux_pin_t sclkPin,
   input wire lsaux_pkg::lsaux_pin_t sdoPin,
   input wire lsaux_pkg::lsaux_pin_t sdiPin,
   input wire lsaux_pkg::lsaux_pin_t refClockOutA,
   input wire lsaux_pkg::lsaux_pin_t refClockOutB
);
   // shadow copies of the control registers, rebuilt from the strobes
   logic [7:0] refCtl_r;
   logic [7:0] monCtl_r;
   logic [3:0] alEn_r;
   logic [3:0] alPol_r;
   wire wrOk = regWr && ce;
   wire cfgHit = wrOk && regAddr[7:2] == 6'h00;
   wire [3:0] losExp = intLos | (alEn_r & (extAlarmInN ^ alPol_r));
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         refCtl_r <= 8'h00;
         monCtl_r <= 8'h00;
         alEn_r <= 4'h0;
         alPol_r <= 4'h0;
      end else begin
         if (wrOk && regAddr == lsaux_pkg::REF_CTRL_ADDR) refCtl_r <= regWrData;
         if (wrOk && regAddr == lsaux_pkg::MON_CTRL_ADDR) monCtl_r <= regWrData;
         if (cfgHit) alEn_r[regAddr[1:0]] <= regWrData[1];
         if (cfgHit) alPol_r[regAddr[1:0]] <= regWrData[0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence losHeldA;
      (losAlarm[refCtl_r[1:0]] && $stable(refCtl_r))[*3];
   endsequence
   sequence losHeldB;
      (losAlarm[refCtl_r[7:6]] && $stable(refCtl_r))[*3];
   endsequence
   // sdo moving while the select was already low
   sequence sdoMoves;
      !(&xcvrSelectN) ##1 (!(&xcvrSelectN) && $changed(sdoPin.out));
   endsequence
   a_los_merge: assert property (
      ($stable(extAlarmInN) && $stable(alEn_r) && $stable(alPol_r))[*3]
      |-> losAlarm == losExp) else $error("combined alarm wrong");
   a_sel_onehot: assert property ($countones(~xcvrSelectN) <= 1)
      else $error("two selects low");
   a_sel_hold: assert property ($fell(&xcvrSelectN) |-> (!(&xcvrSelectN))[*8])
      else $error("select dropped early");
   a_sdo_fall: assert property (
      sdoMoves |-> !sclkPin.out && ($past(sclkPin.out) || $past(sclkPin.out, 2)))
      else $error("sdo moved off a falling clock");
   a_port_drive: assert property (
      (!portModePin)[*4] |-> !sclkPin.oeN && !sdoPin.oeN && sdiPin.oeN)
      else $error("port mode pin drive wrong");
   a_mon_float: assert property ((portModePin && !monCtl_r[4])[*4] |->
      sclkPin.oeN && sdoPin.oeN) else $error("monitor pins not floating");
   a_ref_oe: assert property ($stable(refCtl_r)[*2] |->
      refClockOutA.oeN == !refCtl_r[3] && refClockOutB.oeN == !refCtl_r[5])
      else $error("reference enable wrong");
   a_refa_los: assert property (losHeldA |-> !refClockOutA.out)
      else $error("reference A not low on alarm");
   a_refb_los: assert property (losHeldB |-> !refClockOutB.out)
      else $error("reference B not low on alarm");
   a_rd_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
      else $error("read data outside read slot");
endmodule
bind lsaux_line_side lsaux_line_side_props u_props (.*);

// ==== tb/lsaux_xcvr_model.sv ====
// behavioural model of the four transceivers on the shared serial port
`timescale 1ns/10ps
module lsaux_xcvr_model (
   // serial port
   input wire logic sclk,
   input wire logic sdo,
   input wire logic [3:0] selN,
   output logic sdi,
   // last byte heard from the block
   output logic [7:0] gotByte
);
   logic [7:0] txSh = 8'h00;
   logic [7:0] rxSh = 8'h00;
   logic seenRise = 1'b0;
   wire idle = &selN;
   initial sdi = 1'b0;
   initial gotByte = 8'h00;
   // reply carries the select pattern, so a wrong target shows up
   always @(negedge idle) begin
      txSh = {selN, 4'h5};
      sdi = txSh[7];
      seenRise = 1'b0;
   end
   always @(posedge sclk) if (!idle) begin
      rxSh = {rxSh[6:0], sdo};
      seenRise = 1'b1;
   end
   // the idle clock may be high at select time: a fall before any rise keeps the first bit
   always @(negedge sclk) if (!idle && seenRise) begin
      txSh = {txSh[6:0], 1'b0};
      sdi = txSh[7];
   end
   // released line shows the inverse of its last level
   always @(posedge idle) begin
      gotByte = rxSh;
      sdi = ~sdi;
   end
endmodule

// ==== tb/tb_lsaux_line_side.sv ====
// self-checking bench for the line-side auxiliary block
`timescale 1ns/10ps
module tb_lsaux_line_side;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic lo = 1'b0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic portMode = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] regRdData, gotByte;
   logic [3:0] intLos = 4'h0;
   logic [3:0] extN = 4'h0;
   logic [3:0] losAlarm, selN;
   logic modelSdi;
   lsaux_pkg::lsaux_framer_t [3:0] fr = '0;
   lsaux_pkg::lsaux_pin_t sclkPin, sdoPin, sdiPin, refA, refB;
   int err_total = 0;
   int tests_run = 0;
   wire sdiLine = sdiPin.oeN ? modelSdi : sdiPin.out;
   always #5 clk = ~clk;
   // free-running serial clock source, phase unrelated to clk
   initial #3 forever #80 lo = ~lo;
   lsaux_line_side u_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .framerIn(fr), .intLos(intLos), .losAlarm(losAlarm), .extAlarmInN(extN),
      .portModePin(portMode), .serialClockSourceIn(lo), .xcvrSelectN(selN),
      .sclkPin(sclkPin), .sdoPin(sdoPin), .sdiPinIn(sdiLine), .sdiPin(sdiPin),
      .refClockOutA(refA), .refClockOutB(refB));
   lsaux_xcvr_model u_xcvr (.sclk(sclkPin.out), .sdo(sdoPin.out), .selN(selN),
      .sdi(modelSdi), .gotByte(gotByte));
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      chk8(regRdData, exp);
   endtask
   task automatic t_regs();
      logic [7:0] adr[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h13, 8'h19};
      foreach (adr[i]) rd(adr[i], 8'h00);
      wr(8'h19, 8'hA5);
      rd(8'h19, 8'hA5);
      wr(8'h40, 8'hFF);
      rd(8'h40, 8'h00);
      wr(8'h19, 8'h00);
   endtask
   task automatic t_alarm();
      for (int c = 0; c < 4; c++) for (int p = 0; p < 2; p++) begin
         wr(8'(c), {6'h00, 1'b1, p[0]});
         @(posedge clk) extN[c] <= p[0];
         cyc(4);
         chk8({4'h0, losAlarm}, 8'h00);
         @(posedge clk) extN[c] <= !p[0];
         cyc(4);
         chk8({4'h0, losAlarm}, {4'h0, 4'h1 << c});
         wr(8'(c), 8'h00);
         cyc(2);
         chk8({4'h0, losAlarm}, 8'h00);
         @(posedge clk) extN[c] <= 1'b0;
      end
   endtask
   task automatic t_serial();
      logic [7:0] tx[4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
      int n;
      for (int c = 0; c < 4; c++) begin
         wr(lsaux_pkg::SER_SEL_ADDR, 8'(c));
         // start away from a source edge so the reply has settled
         @(negedge lo);
         wr(lsaux_pkg::SER_DATA_ADDR, tx[c]);
         cyc(1);
         chk8({4'h0, selN}, {4'h0, ~(4'h1 << c)});
         for (n = 0; n < 600 && (&selN) !== 1'b1; n++) cyc(1);
         if (n == 600) begin
            err_total++;
            give_verdict();
         end
         chk8(gotByte, tx[c]);
         rd(lsaux_pkg::SER_DATA_ADDR, {~(4'h1 << c), 4'h5});
      end
   endtask
   task automatic t_monitor();
      @(posedge clk) portMode <= 1'b1;
      @(posedge clk) fr[0].rxFrameBit <= 1'b1;
      @(posedge clk) fr[0].rxNrzData <= 1'b1;
      wr(lsaux_pkg::MON_CTRL_ADDR, 8'h14);
      cyc(6);
      @(posedge clk) fr[0].rxNrzClk <= 1'b1;
      cyc(6);
      chk8({2'h0, sclkPin, sdoPin, sdiPin}, 8'h2A);
      @(posedge clk) fr[0].rxFrameBit <= 1'b0;
      @(posedge clk) fr[0].rxNrzClk <= 1'b0;
      cyc(6);
      // frame pulse must hold through a falling monitor clock
      chk8({2'h0, sclkPin, sdoPin, sdiPin}, 8'h0A);
      wr(lsaux_pkg::MON_CTRL_ADDR, 8'h10);
      cyc(3);
      chk8({7'h0, sdiPin.oeN}, 8'h01);
      wr(lsaux_pkg::MON_CTRL_ADDR, 8'h00);
      cyc(3);
      chk8({6'h0, sclkPin.oeN, sdoPin.oeN}, 8'h03);
      @(posedge clk) fr[3].txNrzClk <= 1'b1;
      wr(lsaux_pkg::MON_CTRL_ADDR, 8'hD1);
      cyc(6);
      chk8({4'h0, sclkPin, sdoPin}, 8'h08);
      @(posedge clk) portMode <= 1'b0;
      cyc(6);
   endtask
   task automatic t_refs();
      for (int s = 0; s < 4; s++) begin
         @(posedge clk) for (int i = 0; i < 4; i++) fr[i].lineClk <= (i == s);
         @(posedge clk) for (int i = 0; i < 4; i++) fr[i].frameClk <= (i != s);
         wr(8'h19, {2'(3 - s), 3'b111, 1'b0, 2'(s)});
         cyc(6);
         chk8({4'h0, refA, refB}, 8'h08);
         wr(8'h19, {2'(3 - s), 3'b101, 1'b0, 2'(s)});
         cyc(6);
         chk8({4'h0, refA, refB}, 8'h02);
         wr(8'h19, {2'(3 - s), 3'b111, 1'b0, 2'(s)});
         @(posedge clk) intLos[s] <= 1'b1;
         cyc(6);
         chk8({4'h0, refA, refB}, 8'h00);
         @(posedge clk) intLos[s] <= 1'b0;
      end
      wr(8'h19, 8'h00);
      cyc(3);
      chk8({6'h0, refA.oeN, refB.oeN}, 8'h03);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_alarm();
      t_serial();
      t_monitor();
      t_refs();
      give_verdict();
   end
endmodule
